// File: hw/eeprom_protect_pkg.sv
package eeprom_protect_pkg;

  // slave address prefixes, upper four bits of the first byte
  localparam logic [3:0] PREFIX_NORMAL  = 4'hA;
  localparam logic [3:0] PREFIX_PROTECT = 4'h6;

  // first byte field positions
  localparam int PREFIX_MSB = 7;
  localparam int PREFIX_LSB = 4;
  localparam int SEL_MSB    = 3;
  localparam int SEL_LSB    = 1;
  localparam int DIR_BIT    = 0;
  localparam int SEL_ONE    = 1;
  localparam int SEL_TWO    = 2;
  localparam int SEL_ZERO   = 0;

  // byte address bit that splits the array into halves
  localparam int ADDR_HALF_BIT = 7;

  // delivered state of both protect flags
  localparam logic FLAG_DELIVERED = 1'b0;

  // timing: self-timed write cycle, longest time
  localparam int CLK_PERIOD_NS  = 20;
  localparam int WRITE_TIME_NS  = 5000000;
  localparam int WRITE_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COMMAND,
    ST_ADDRESS,
    ST_DATA,
    ST_STATUS_ADDRESS,
    ST_STATUS_DATA,
    ST_IGNORE
  } state_type;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ARRAY_WRITE,
    CMD_SET_REVERSIBLE,
    CMD_CLEAR_REVERSIBLE,
    CMD_SET_PERMANENT
  } cmd_type;

endpackage : eeprom_protect_pkg

// File: hw/eeprom_write_protection.sv
`timescale 1ns/1ps
// How it works
// - protect pin high: ack command and address, noack data, no write cycle
// - pin low: upper half writes always acked and written
// - either flag set blocks lower half data byte with noack
// - each flag kept as its own non-volatile bit via nv ports
// - both flags read as zero in delivered state
// - reversible commands: prefix 0110, select 0,x,1 matching pins
// - direction 0 sets or clears, direction 1 reads reversible status
// - reversible flag changes only if protect pin low whole command
// - reversible status reads ignore protect pin, stop may follow ack
// - ack rules for reversible status, set and clear commands
// - permanent flag never clears, protects lower half regardless of pin
// - permanent command: prefix 0110, select matching pins, direction 0
// - ack rules for permanent set and status read
// - permanent flag set: noack every 0110 slave address
// - prefix 1010 normal access, 0110 protect commands
module eeprom_write_protection #(
  parameter int WRITE_CYCLES = eeprom_protect_pkg::WRITE_CYCLES
) (
  // clock, reset, enable
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire logic       CLK_EN,
  // decoded bus events from the bus front end
  input  wire logic       BUS_START,
  input  wire logic       BUS_STOP,
  input  wire logic       BYTE_VALID,
  input  wire logic [7:0] BYTE_DATA,
  // device pins
  input  wire logic       PROTECT_PIN,
  input  wire logic       SELECT_PIN_ZERO,
  input  wire logic       SELECT_PIN_ZERO_HV,
  input  wire logic       SELECT_PIN_ONE,
  input  wire logic       SELECT_PIN_TWO,
  // non-volatile flag store
  input  wire logic       NV_REVERSIBLE_IN,
  input  wire logic       NV_PERMANENT_IN,
  output logic            NV_REVERSIBLE_WRITE,
  output logic            NV_REVERSIBLE_DATA,
  output logic            NV_PERMANENT_WRITE,
  // acknowledge decision and write control
  output logic            ACK_VALID,
  output logic            ACK,
  output logic            WRITE_CYCLE_START,
  output logic            BUSY,
  // flag status
  output logic            REVERSIBLE_PROTECT_FLAG,
  output logic            PERMANENT_PROTECT_FLAG
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam int NPINS = 5;

  eeprom_protect_pkg::state_type state_r;
  eeprom_protect_pkg::cmd_type   cmd_r;
  logic [NPINS-1:0]              sync1_r;
  logic [NPINS-1:0]              sync2_r;
  logic [NPINS-1:0]              sync3_r;
  logic [NPINS-1:0]              pins_r;
  logic                          nv_loaded_r;
  logic                          pending_r;
  logic                          wp_seen_r;
  logic [CNT_W-1:0]              busy_cnt_r;
  logic                          wp;
  logic                          hv;
  logic [2:0]                    sel_pins;
  logic [3:0]                    prefix;
  logic [2:0]                    sel;
  logic                          dir;
  logic                          lower_allowed;
  logic                          commit;

  // pin order: protect, zero, zero_hv, one, two
  assign wp       = pins_r[0];
  assign hv       = pins_r[2];
  assign sel_pins = {pins_r[4], pins_r[3], pins_r[1]};
  assign prefix   = BYTE_DATA[eeprom_protect_pkg::PREFIX_MSB:eeprom_protect_pkg::PREFIX_LSB];
  assign sel      = BYTE_DATA[eeprom_protect_pkg::SEL_MSB:eeprom_protect_pkg::SEL_LSB];
  assign dir      = BYTE_DATA[eeprom_protect_pkg::DIR_BIT];

  // lower half writable only with both flags clear
  assign lower_allowed = !REVERSIBLE_PROTECT_FLAG && !PERMANENT_PROTECT_FLAG;

  // a protect update needs the pin low over the whole command, stop included
  assign commit = BUS_STOP && pending_r && !wp_seen_r && !wp;

  function automatic logic sel_match(input logic [2:0] s, input logic [2:0] p);
    sel_match = (s == p);
  endfunction : sel_match

  // reversible commands: select two low, select one as pin, zero logically high
  function automatic logic rev_match(input logic [2:0] s, input logic [2:0] p);
    rev_match = !s[eeprom_protect_pkg::SEL_TWO] && !p[eeprom_protect_pkg::SEL_TWO] &&
                (s[eeprom_protect_pkg::SEL_ONE] == p[eeprom_protect_pkg::SEL_ONE]) &&
                s[eeprom_protect_pkg::SEL_ZERO];
  endfunction : rev_match

  // pins come from outside: three stages, change taken when stages two and three agree
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pins_r  <= '0;
    end else if (CLK_EN) begin
      sync1_r <= {SELECT_PIN_TWO, SELECT_PIN_ONE, SELECT_PIN_ZERO_HV,
                  SELECT_PIN_ZERO, PROTECT_PIN};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < NPINS; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pins_r[i] <= sync3_r[i];
        end
      end
    end
  end

  // flags: delivered value at reset, then loaded once from the nv store
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      REVERSIBLE_PROTECT_FLAG <= eeprom_protect_pkg::FLAG_DELIVERED;
      PERMANENT_PROTECT_FLAG  <= eeprom_protect_pkg::FLAG_DELIVERED;
      nv_loaded_r             <= 1'b0;
    end else if (CLK_EN) begin
      if (!nv_loaded_r) begin
        REVERSIBLE_PROTECT_FLAG <= NV_REVERSIBLE_IN;
        PERMANENT_PROTECT_FLAG  <= NV_PERMANENT_IN;
        nv_loaded_r             <= 1'b1;
      end else if (commit) begin
        case (cmd_r)
          eeprom_protect_pkg::CMD_SET_REVERSIBLE:   REVERSIBLE_PROTECT_FLAG <= 1'b1;
          eeprom_protect_pkg::CMD_CLEAR_REVERSIBLE: REVERSIBLE_PROTECT_FLAG <= 1'b0;
          // only a set path exists for the permanent flag
          eeprom_protect_pkg::CMD_SET_PERMANENT:    PERMANENT_PROTECT_FLAG  <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // nv store write strobes, one cycle each
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      NV_REVERSIBLE_WRITE <= 1'b0;
      NV_REVERSIBLE_DATA  <= 1'b0;
      NV_PERMANENT_WRITE  <= 1'b0;
    end else if (CLK_EN) begin
      NV_REVERSIBLE_WRITE <= commit && nv_loaded_r &&
                             (cmd_r == eeprom_protect_pkg::CMD_SET_REVERSIBLE ||
                              cmd_r == eeprom_protect_pkg::CMD_CLEAR_REVERSIBLE);
      NV_PERMANENT_WRITE  <= commit && nv_loaded_r &&
                             (cmd_r == eeprom_protect_pkg::CMD_SET_PERMANENT);
      if (commit && nv_loaded_r) begin
        NV_REVERSIBLE_DATA <= (cmd_r == eeprom_protect_pkg::CMD_SET_REVERSIBLE);
      end
    end
  end

  // write cycle timer: device answers nothing while it runs
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      busy_cnt_r        <= '0;
      BUSY              <= 1'b0;
      WRITE_CYCLE_START <= 1'b0;
    end else if (CLK_EN) begin
      WRITE_CYCLE_START <= commit && nv_loaded_r;
      if (commit && nv_loaded_r) begin
        busy_cnt_r <= CNT_W'(WRITE_CYCLES);
        BUSY       <= 1'b1;
      end else if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - CNT_W'(1);
        BUSY       <= (busy_cnt_r != CNT_W'(1));
      end
    end
  end

  // protect pin history over the current command
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      wp_seen_r <= 1'b0;
    end else if (CLK_EN) begin
      if (BUS_START) begin
        wp_seen_r <= wp;
      end else if (wp) begin
        wp_seen_r <= 1'b1;
      end
    end
  end

  // byte sequencer and acknowledge decision
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_r   <= eeprom_protect_pkg::ST_IDLE;
      cmd_r     <= eeprom_protect_pkg::CMD_NONE;
      pending_r <= 1'b0;
      ACK_VALID <= 1'b0;
      ACK       <= 1'b0;
    end else if (CLK_EN) begin
      ACK_VALID <= 1'b0;
      if (BUS_STOP) begin
        state_r   <= eeprom_protect_pkg::ST_IDLE;
        cmd_r     <= eeprom_protect_pkg::CMD_NONE;
        pending_r <= 1'b0;
      end else if (BUS_START) begin
        // a repeated start drops any write gathered so far
        state_r   <= eeprom_protect_pkg::ST_COMMAND;
        cmd_r     <= eeprom_protect_pkg::CMD_NONE;
        pending_r <= 1'b0;
      end else if (BYTE_VALID) begin
        ACK_VALID <= 1'b1;
        ACK       <= 1'b0;
        state_r   <= eeprom_protect_pkg::ST_IGNORE;
        case (state_r)
          eeprom_protect_pkg::ST_COMMAND: begin
            if (BUSY || !nv_loaded_r) begin
              ACK <= 1'b0;
            end else if (prefix == eeprom_protect_pkg::PREFIX_NORMAL) begin
              if (sel_match(sel, sel_pins)) begin
                ACK <= 1'b1;
                if (!dir) begin
                  cmd_r   <= eeprom_protect_pkg::CMD_ARRAY_WRITE;
                  state_r <= eeprom_protect_pkg::ST_ADDRESS;
                end
              end
            end else if (prefix == eeprom_protect_pkg::PREFIX_PROTECT) begin
              if (PERMANENT_PROTECT_FLAG) begin
                ACK <= 1'b0;
              end else if (hv) begin
                if (rev_match(sel, sel_pins)) begin
                  if (dir) begin
                    // status reads look at the flags only, never the pin
                    ACK <= sel[eeprom_protect_pkg::SEL_ONE] ? 1'b1 :
                           !REVERSIBLE_PROTECT_FLAG;
                  end else if (!sel[eeprom_protect_pkg::SEL_ONE]) begin
                    ACK <= !REVERSIBLE_PROTECT_FLAG;
                    if (!REVERSIBLE_PROTECT_FLAG) begin
                      cmd_r   <= eeprom_protect_pkg::CMD_SET_REVERSIBLE;
                      state_r <= eeprom_protect_pkg::ST_ADDRESS;
                    end
                  end else begin
                    ACK     <= 1'b1;
                    cmd_r   <= eeprom_protect_pkg::CMD_CLEAR_REVERSIBLE;
                    state_r <= eeprom_protect_pkg::ST_ADDRESS;
                  end
                end
              end else if (sel_match(sel, sel_pins)) begin
                ACK <= 1'b1;
                if (dir) begin
                  state_r <= eeprom_protect_pkg::ST_STATUS_ADDRESS;
                end else begin
                  cmd_r   <= eeprom_protect_pkg::CMD_SET_PERMANENT;
                  state_r <= eeprom_protect_pkg::ST_ADDRESS;
                end
              end
            end
          end
          eeprom_protect_pkg::ST_ADDRESS: begin
            // real or dummy byte address, always acknowledged
            ACK     <= 1'b1;
            state_r <= eeprom_protect_pkg::ST_DATA;
            if (cmd_r == eeprom_protect_pkg::CMD_ARRAY_WRITE) begin
              // msb stays fixed over a page, so one check covers the page
              if (BYTE_DATA[eeprom_protect_pkg::ADDR_HALF_BIT]) begin
                cmd_r <= eeprom_protect_pkg::CMD_ARRAY_WRITE;
              end else if (!lower_allowed) begin
                cmd_r <= eeprom_protect_pkg::CMD_NONE;
              end
            end
          end
          eeprom_protect_pkg::ST_DATA: begin
            if (wp || wp_seen_r) begin
              ACK <= 1'b0;
            end else if (cmd_r == eeprom_protect_pkg::CMD_NONE) begin
              ACK <= 1'b0;
            end else begin
              ACK       <= 1'b1;
              pending_r <= 1'b1;
              if (cmd_r == eeprom_protect_pkg::CMD_ARRAY_WRITE) begin
                state_r <= eeprom_protect_pkg::ST_DATA;
              end
            end
          end
          eeprom_protect_pkg::ST_STATUS_ADDRESS: begin
            ACK     <= 1'b0;
            state_r <= eeprom_protect_pkg::ST_STATUS_DATA;
          end
          default: begin
            ACK <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : eeprom_write_protection

// File: verification/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input  wire logic       clk,
  // bus events towards the block
  output logic            bus_start  = 1'h0,
  output logic            bus_stop   = 1'h0,
  output logic            byte_valid = 1'h0,
  output logic [7:0]      byte_data  = 8'h00,
  // answers
  input  wire logic       ack_valid,
  input  wire logic       ack,
  input  wire logic       write_start,
  input  wire logic       busy,
  // non-volatile flag store
  input  wire logic       nv_rev_write,
  input  wire logic       nv_rev_data,
  input  wire logic       nv_perm_write,
  output logic            nv_rev     = eeprom_protect_pkg::FLAG_DELIVERED,
  output logic            nv_perm    = eeprom_protect_pkg::FLAG_DELIVERED
);
  logic hung = 1'h0;
  // bits survive a reset of the block, as across power loss
  always @(posedge clk) begin
    if (nv_rev_write === 1'h1) nv_rev <= nv_rev_data;
    if (nv_perm_write === 1'h1) nv_perm <= 1'h1;
  end
  // res holds write started, then the answer to each byte sent
  task automatic frame(input logic [7:0] b0, b1, b2, input int n, output logic [3:0] res);
    logic [7:0] b [3];
    int         i;
    b   = '{b0, b1, b2};
    res = 4'h0;
    for (i = 0; i < 100 && busy !== 1'h0; i++) @(posedge clk);
    if (busy !== 1'h0) hung = 1'h1;
    @(posedge clk);
    #1 bus_start = 1'h1;
    @(posedge clk);
    #1 bus_start = 1'h0;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      #1 byte_valid = 1'h1;
      byte_data = b[i];
      @(posedge clk);
      #1 byte_valid = 1'h0;
      res[2-i] = ack_valid === 1'h1 && ack === 1'h1;
    end
    @(posedge clk);
    #1 bus_stop = 1'h1;
    @(posedge clk);
    #1 bus_stop = 1'h0;
    for (i = 0; i < 3; i++) begin
      if (write_start === 1'h1) res[3] = 1'h1;
      @(posedge clk);
      #1;
    end
  endtask : frame
endmodule : bus_master_model

// File: verification/eeprom_write_protection_sva.sv
`timescale 1ns/1ps
module eeprom_write_protection_sva #(
  parameter int WRITE_CYCLES = eeprom_protect_pkg::WRITE_CYCLES
) (
  // clock, reset, enable
  input wire logic       REF_CLK,
  input wire logic       NRST,
  input wire logic       CLK_EN,
  // bus events
  input wire logic       BUS_START,
  input wire logic       BUS_STOP,
  input wire logic       BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  // protect pin
  input wire logic       PROTECT_PIN,
  // answers and write control
  input wire logic       ACK_VALID,
  input wire logic       ACK,
  input wire logic       WRITE_CYCLE_START,
  input wire logic       BUSY,
  // nv store and flags
  input wire logic       NV_REVERSIBLE_WRITE,
  input wire logic       NV_REVERSIBLE_DATA,
  input wire logic       NV_PERMANENT_WRITE,
  input wire logic       REVERSIBLE_PROTECT_FLAG,
  input wire logic       PERMANENT_PROTECT_FLAG
);
  logic first_r;
  int   busy_cnt_r;
  logic taken;
  assign taken = CLK_EN && BYTE_VALID && !BUS_START && !BUS_STOP;
  // next byte after a start is a slave address
  always_ff @(posedge REF_CLK) begin
    if (!NRST) first_r <= 1'h0;
    else if (CLK_EN && (BUS_START || BYTE_VALID)) first_r <= BUS_START;
  end
  always_ff @(posedge REF_CLK) begin
    if (!NRST) busy_cnt_r <= 0;
    else if (CLK_EN) busy_cnt_r <= BUSY ? busy_cnt_r + 1 : 0;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  a_ack_follows: assert property (taken |=> ACK_VALID)
    else $error("answer missing after byte");
  a_ack_cause: assert property (ACK_VALID |-> $past(BYTE_VALID))
    else $error("answer without byte");
  a_pin_blocks: assert property (PROTECT_PIN [*8] |-> !WRITE_CYCLE_START)
    else $error("write started with protect pin high");
  a_perm_sticky: assert property (PERMANENT_PROTECT_FLAG |=> PERMANENT_PROTECT_FLAG)
    else $error("permanent flag cleared");
  a_perm_store: assert property (NV_PERMANENT_WRITE |->
    WRITE_CYCLE_START && PERMANENT_PROTECT_FLAG)
    else $error("permanent store write mismatch");
  a_rev_store: assert property (NV_REVERSIBLE_WRITE |->
    WRITE_CYCLE_START && NV_REVERSIBLE_DATA == REVERSIBLE_PROTECT_FLAG)
    else $error("reversible store write mismatch");
  a_flag_cause: assert property ($past(NRST, 3) &&
    ($changed(REVERSIBLE_PROTECT_FLAG) || $changed(PERMANENT_PROTECT_FLAG)) |->
    WRITE_CYCLE_START)
    else $error("flag changed without write cycle");
  a_perm_prefix: assert property (first_r && taken && PERMANENT_PROTECT_FLAG &&
    BYTE_DATA[eeprom_protect_pkg::PREFIX_MSB:eeprom_protect_pkg::PREFIX_LSB] ==
    eeprom_protect_pkg::PREFIX_PROTECT |=> ACK_VALID && !ACK)
    else $error("protect prefix acked while permanent");
  a_busy_hold: assert property (WRITE_CYCLE_START |-> BUSY [*8])
    else $error("busy dropped early");
  a_busy_bound: assert property (busy_cnt_r <= WRITE_CYCLES)
    else $error("busy too long");
endmodule : eeprom_write_protection_sva
bind eeprom_write_protection eeprom_write_protection_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
  .REF_CLK(REF_CLK), .NRST(NRST), .CLK_EN(CLK_EN), .BUS_START(BUS_START), .BUS_STOP(BUS_STOP),
  .BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA), .PROTECT_PIN(PROTECT_PIN), .ACK(ACK),
  .ACK_VALID(ACK_VALID), .WRITE_CYCLE_START(WRITE_CYCLE_START), .BUSY(BUSY),
  .NV_REVERSIBLE_WRITE(NV_REVERSIBLE_WRITE), .NV_REVERSIBLE_DATA(NV_REVERSIBLE_DATA),
  .NV_PERMANENT_WRITE(NV_PERMANENT_WRITE), .REVERSIBLE_PROTECT_FLAG(REVERSIBLE_PROTECT_FLAG),
  .PERMANENT_PROTECT_FLAG(PERMANENT_PROTECT_FLAG)
);

// File: verification/eeprom_write_protection_tb.sv
`timescale 1ns/1ps
module eeprom_write_protection_tb;
  localparam int WC = 20;
  logic       clk = 1'h0;
  logic       nrst = 1'h0;
  logic       prot = 1'h0, hv = 1'h0, s2 = 1'h0, s1 = 1'h0, s0 = 1'h0;
  logic       bs, bp, bv, ackv, ack, wcs, busy, nvrw, nvrd, nvpw, nvr, nvp, rflag, pflag;
  logic [7:0] bd;
  int         error_cnt = 0;
  int         compares = 0;
  always #10 clk = ~clk;
  eeprom_write_protection #(.WRITE_CYCLES(WC)) u_dut (
    .REF_CLK(clk), .NRST(nrst), .CLK_EN(1'h1), .BUS_START(bs), .BUS_STOP(bp),
    .BYTE_VALID(bv), .BYTE_DATA(bd), .PROTECT_PIN(prot), .SELECT_PIN_ZERO(s0),
    .SELECT_PIN_ZERO_HV(hv), .SELECT_PIN_ONE(s1), .SELECT_PIN_TWO(s2),
    .NV_REVERSIBLE_IN(nvr), .NV_PERMANENT_IN(nvp), .NV_REVERSIBLE_WRITE(nvrw),
    .NV_REVERSIBLE_DATA(nvrd), .NV_PERMANENT_WRITE(nvpw), .ACK_VALID(ackv), .ACK(ack),
    .WRITE_CYCLE_START(wcs), .BUSY(busy), .REVERSIBLE_PROTECT_FLAG(rflag),
    .PERMANENT_PROTECT_FLAG(pflag)
  );
  bus_master_model u_master (
    .clk(clk), .bus_start(bs), .bus_stop(bp), .byte_valid(bv), .byte_data(bd),
    .ack_valid(ackv), .ack(ack), .write_start(wcs), .busy(busy), .nv_rev_write(nvrw),
    .nv_rev_data(nvrd), .nv_perm_write(nvpw), .nv_rev(nvr), .nv_perm(nvp)
  );
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // expected: write started, then answers to command, address, data
  task automatic run(input string name, input logic [7:0] b0, b1, b2, input int n,
                     input logic [3:0] exp);
    logic [3:0] r;
    u_master.frame(b0, b1, b2, n, r);
    if (u_master.hung === 1'h1) begin
      error_cnt++;
      complete_run();
    end else begin
      chk(name, exp, r);
    end
  endtask : run
  // pins pass a synchroniser, so let them settle before a frame
  task automatic pins(input logic [4:0] v);
    {prot, hv, s2, s1, s0} = v;
    repeat (6) @(posedge clk);
    #1;
  endtask : pins
  task automatic do_reset();
    nrst = 1'h0;
    repeat (10) @(posedge clk);
    #1 nrst = 1'h1;
    repeat (6) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic t_plain();
    pins(5'h00);
    chk("flags", 4'h0, {2'h0, rflag, pflag});
    run("low_write", 8'hA0, 8'h10, 8'h55, 3, 4'hF);
    run("high_write", 8'hA0, 8'hFF, 8'h55, 3, 4'hF);
    run("normal_read", 8'hA1, 8'h00, 8'h00, 1, 4'h4);
  endtask : t_plain
  task automatic t_wp_pin();
    pins(5'h10);
    run("pin_high_up", 8'hA0, 8'h90, 8'h55, 3, 4'h6);
    run("pin_high_low", 8'hA0, 8'h00, 8'h55, 3, 4'h6);
  endtask : t_wp_pin
  task automatic t_reversible();
    pins(5'h09);
    run("rd_set_free", 8'h63, 8'h00, 8'h00, 1, 4'h4);
    run("set_rev", 8'h62, 8'h00, 8'h00, 3, 4'hF);
    chk("flags", 4'h2, {2'h0, rflag, pflag});
    run("rd_set_busy", 8'h63, 8'h00, 8'h00, 1, 4'h0);
    run("set_again", 8'h62, 8'h00, 8'h00, 1, 4'h0);
    run("low_blocked", 8'hA2, 8'h10, 8'h55, 3, 4'h6);
    run("up_free", 8'hA2, 8'h80, 8'h55, 3, 4'hF);
    pins(5'h1B);
    run("clr_pin_high", 8'h66, 8'h00, 8'h00, 3, 4'h6);
    chk("flags", 4'h2, {2'h0, rflag, pflag});
    run("rd_clr_pin", 8'h67, 8'h00, 8'h00, 1, 4'h4);
    pins(5'h0B);
    run("clr_rev", 8'h66, 8'h00, 8'h00, 3, 4'hF);
    chk("flags", 4'h0, {2'h0, rflag, pflag});
  endtask : t_reversible
  task automatic t_permanent();
    pins(5'h05);
    run("rd_perm", 8'h6B, 8'h00, 8'h00, 3, 4'h4);
    chk("flags", 4'h0, {2'h0, rflag, pflag});
    run("set_perm", 8'h6A, 8'h00, 8'h00, 3, 4'hF);
    chk("flags", 4'h1, {2'h0, rflag, pflag});
    run("rd_perm_set", 8'h6B, 8'h00, 8'h00, 1, 4'h0);
    run("set_perm_set", 8'h6A, 8'h00, 8'h00, 1, 4'h0);
    run("low_locked", 8'hAA, 8'h10, 8'h55, 3, 4'h6);
    do_reset();
    chk("flags", 4'h1, {2'h0, rflag, pflag});
    pins(5'h09);
    run("rev_locked", 8'h62, 8'h00, 8'h00, 1, 4'h0);
    run("normal_ok", 8'hA2, 8'h80, 8'h55, 3, 4'hF);
  endtask : t_permanent
  initial begin
    do_reset();
    t_plain();
    t_wp_pin();
    t_reversible();
    t_permanent();
    complete_run();
  end
endmodule : eeprom_write_protection_tb
